/* File: logic/branch_stack_map.vh */
/*
  Constants of the branch record stack: register indexes on the
  plain register port, field positions, reset values and the
  record format codes.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef BRANCH_STACK_MAP_VH
`define BRANCH_STACK_MAP_VH

// depth and pointer width
`define STACK_DEPTH 32
`define PTR_BITS 5
`define ADDR_BITS 7

// register index groups, one 64-bit register per index
`define SRC_ARRAY_BASE 7'h00
`define DST_ARRAY_BASE 7'h20
`define INFO_ARRAY_BASE 7'h40
`define TOP_REG_IDX 7'h60
`define DEBUG_CTRL_IDX 7'h61
`define PERF_CAP_IDX 7'h62
`define FEATURE_ID_IDX 7'h63
`define FORMAT_SEL_IDX 7'h64

// field positions
`define RECORD_EN_BIT 0
`define CAP_PRESENT_BIT 15
`define LEGACY_PACK_BIT 8
`define MISPRED_BIT 63
`define IN_TX_BIT 62
`define TX_ABORT_BIT 61
`define CYCLE_HI 63
`define CYCLE_LO 48

// reset values
`define TOP_RESET 5'h00
`define DEBUG_CTRL_RESET 1'h0
`define FORMAT_RESET 6'h05
`define LEGACY_RESET 1'h0

// record format codes
`define FMT_OFS32 6'h00
`define FMT_LIN64 6'h01
`define FMT_EFF64 6'h02
`define FMT_EFF_FLAGS 6'h03
`define FMT_EFF_TX 6'h04
`define FMT_EFF_INFO 6'h05
`define FMT_LIN_CYC 6'h06
`define FMT_LIN_INFO 6'h07

`endif

/* File: logic/last_branch_record_stack.v */
/*
  Circular stack of branch records: source, destination and info
  registers per entry, a top pointer, a recording enable, the
  format capability and the feature bit, reached over a plain
  register port with read data one cycle after the read strobe.
  Assumes the core presents one retired control transfer per
  cycle on the same clock, with a one-cycle valid strobe.
*/
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "branch_stack_map.vh"

// Notes on behaviour
// - every taken branch and every other ip change, interrupts and faults, is recorded.
// - the stack holds N entries, each a pair of 64-bit registers.
// - source addresses sit in N consecutive registers, entry 0 to N-1.
// - destinations sit in N consecutive registers, paired index for index.
// - low M bits of the top register index the newest record.
// - depth is 4, 8, 16 or 32; here 32, pointer 0 to 31, with info registers.
// - in 64-bit mode full-width addresses are stored.
// - outside 64-bit mode upper 32 address bits are stored as zero.
// - a 6-bit capability field reports the record format in use.
// - format 0 stores 32-bit offsets within the current code segment.
// - format 1 stores 64-bit linear addresses.
// - format 2 stores 64-bit effective offsets.
// - format 3 adds misprediction in the top source bit.
// - format 4 adds misprediction and transaction flags in upper source bits.
// - format 5 puts misprediction, transaction flags and cycles in info registers.
// - format 6 stores linear addresses, misprediction, cycles in upper 16 destination bits.
// - format 7 stores linear addresses, misprediction and cycles in info registers.
// - a feature bit 15 advertises that the capability register exists.
// - legacy packing puts 32-bit destination high and source low in one register.
// - recording only while enable bit 0 of the debug control register is set.

module last_branch_record_stack
(
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [`ADDR_BITS-1:0] regAddr,
  input wire [63:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [63:0] regRdData_ff,
  // retired control transfer from the core
  input wire xferValid,
  input wire [63:0] xferSrc,
  input wire [63:0] xferDst,
  input wire [63:0] codeSegBase,
  input wire longMode,
  input wire xferMispred,
  input wire xferInTx,
  input wire xferTxAbort
);

  // stack storage, data only, so no reset
  reg [63:0] srcMem [0:`STACK_DEPTH-1];
  reg [63:0] dstMem [0:`STACK_DEPTH-1];
  reg [63:0] infoMem [0:`STACK_DEPTH-1];

  // control state
  reg [`PTR_BITS-1:0] top_ff;
  reg recEnable_ff;
  reg [5:0] format_ff;
  reg legacyPack_ff;
  reg [15:0] cycles_ff;

  reg [`PTR_BITS-1:0] nxt_top;
  reg [15:0] nxt_cycles;
  reg [63:0] nxt_rdData;

  wire capture;
  wire [`PTR_BITS-1:0] slot;
  wire [`PTR_BITS-1:0] regIdx;
  wire inSrc;
  wire inDst;
  wire inInfo;
  wire [63:0] linSrc;
  wire [63:0] linDst;
  reg [63:0] recSrc;
  reg [63:0] recDst;
  reg [63:0] recInfo;
  reg useLinear;
  reg [63:0] baseSrc;
  reg [63:0] baseDst;

  // any ip change the core reports counts, gated by the enable
  assign capture = xferValid & recEnable_ff;

  // new record lands one past the current newest, wrapping at 32
  assign slot = top_ff + 5'h01;

  // index decode: upper two bits pick the array
  assign regIdx = regAddr[`PTR_BITS-1:0];
  assign inSrc = (regAddr[6:5] == 2'h0);
  assign inDst = (regAddr[6:5] == 2'h1);
  assign inInfo = (regAddr[6:5] == 2'h2);

  // linear address is segment base plus effective offset
  assign linSrc = codeSegBase + xferSrc;
  assign linDst = codeSegBase + xferDst;

  // address form by format, then 64-bit mode clamp
  always @*
  begin
    case (format_ff)
      `FMT_LIN64, `FMT_LIN_CYC, `FMT_LIN_INFO:
        useLinear = 1'b1;
      default:
        useLinear = 1'b0;
    endcase
    baseSrc = useLinear ? linSrc : xferSrc;
    baseDst = useLinear ? linDst : xferDst;
    if (format_ff == `FMT_OFS32)
    begin
      // offset within the code segment only
      baseSrc = {32'h00000000, xferSrc[31:0]};
      baseDst = {32'h00000000, xferDst[31:0]};
    end
    if (!longMode)
    begin
      baseSrc[63:32] = 32'h00000000;
      baseDst[63:32] = 32'h00000000;
    end
  end

  // flag placement; flags overlay the upper address bits in formats 3, 4 and 6, and go to the info word in formats 5 and 7
  always @*
  begin
    recSrc = baseSrc;
    recDst = baseDst;
    recInfo = 64'h0000000000000000;
    case (format_ff)
      `FMT_EFF_FLAGS:
      begin
        recSrc[`MISPRED_BIT] = xferMispred;
      end
      `FMT_EFF_TX:
      begin
        recSrc[`MISPRED_BIT] = xferMispred;
        recSrc[`IN_TX_BIT] = xferInTx;
        recSrc[`TX_ABORT_BIT] = xferTxAbort;
      end
      `FMT_EFF_INFO:
      begin
        recInfo[`MISPRED_BIT] = xferMispred;
        recInfo[`IN_TX_BIT] = xferInTx;
        recInfo[`TX_ABORT_BIT] = xferTxAbort;
        recInfo[15:0] = cycles_ff;
      end
      `FMT_LIN_CYC:
      begin
        recSrc[`MISPRED_BIT] = xferMispred;
        recDst[`CYCLE_HI:`CYCLE_LO] = cycles_ff;
      end
      `FMT_LIN_INFO:
      begin
        recInfo[`MISPRED_BIT] = xferMispred;
        recInfo[15:0] = cycles_ff;
      end
      default:
      begin
        recInfo = 64'h0000000000000000;
      end
    endcase
    if (legacyPack_ff)
    begin
      // one register per entry, destination high, source low
      recSrc = {xferDst[31:0], xferSrc[31:0]};
    end
  end

  // pointer and elapsed-cycle counter
  always @*
  begin
    nxt_top = top_ff;
    if (regWrEn && regAddr == `TOP_REG_IDX)
    begin
      nxt_top = regWrData[`PTR_BITS-1:0];
    end
    // a record wins over a software pointer write
    if (capture)
    begin
      nxt_top = slot;
    end
    nxt_cycles = cycles_ff;
    if (capture)
    begin
      nxt_cycles = 16'h0000;
    end
    else if (cycles_ff != 16'hffff)
    begin
      // saturate rather than wrap, a wrapped count would lie
      nxt_cycles = cycles_ff + 16'h0001;
    end
  end

  // control registers
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      top_ff <= `TOP_RESET;
      recEnable_ff <= `DEBUG_CTRL_RESET;
      format_ff <= `FORMAT_RESET;
      legacyPack_ff <= `LEGACY_RESET;
      cycles_ff <= 16'h0000;
    end
    else
    begin
      top_ff <= nxt_top;
      cycles_ff <= nxt_cycles;
      if (regWrEn && regAddr == `DEBUG_CTRL_IDX)
      begin
        recEnable_ff <= regWrData[`RECORD_EN_BIT];
      end
      if (regWrEn && regAddr == `FORMAT_SEL_IDX)
      begin
        format_ff <= regWrData[5:0];
        legacyPack_ff <= regWrData[`LEGACY_PACK_BIT];
      end
    end
  end

  // stack arrays; a record beats a software write to the same slot
  always @(posedge clk)
  begin
    if (regWrEn && inSrc)
    begin
      srcMem[regIdx] <= regWrData;
    end
    if (regWrEn && inDst)
    begin
      dstMem[regIdx] <= regWrData;
    end
    if (regWrEn && inInfo)
    begin
      infoMem[regIdx] <= regWrData;
    end
    if (capture)
    begin
      srcMem[slot] <= recSrc;
      infoMem[slot] <= recInfo;
      if (!legacyPack_ff)
      begin
        dstMem[slot] <= recDst;
      end
    end
  end

  // read mux; unmapped and reserved bits read zero
  always @*
  begin
    nxt_rdData = 64'h0000000000000000;
    if (inSrc)
    begin
      nxt_rdData = srcMem[regIdx];
    end
    else if (inDst)
    begin
      nxt_rdData = dstMem[regIdx];
    end
    else if (inInfo)
    begin
      nxt_rdData = infoMem[regIdx];
    end
    else
    begin
      case (regAddr)
        `TOP_REG_IDX:
          nxt_rdData[`PTR_BITS-1:0] = top_ff;
        `DEBUG_CTRL_IDX:
          nxt_rdData[`RECORD_EN_BIT] = recEnable_ff;
        `PERF_CAP_IDX:
          nxt_rdData[5:0] = format_ff;
        `FEATURE_ID_IDX:
          nxt_rdData[`CAP_PRESENT_BIT] = 1'b1;
        `FORMAT_SEL_IDX:
        begin
          nxt_rdData[5:0] = format_ff;
          nxt_rdData[`LEGACY_PACK_BIT] = legacyPack_ff;
        end
        default:
          nxt_rdData = 64'h0000000000000000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      regRdData_ff <= 64'h0000000000000000;
    end
    else if (regRdEn)
    begin
      regRdData_ff <= nxt_rdData;
    end
    else
    begin
      regRdData_ff <= 64'h0000000000000000;
    end
  end

endmodule

`default_nettype wire

/* File: dv/branch_stack_chk.sv */
/* checker for the branch record stack register port.
   assumes a bind onto the stack top and the map header on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "branch_stack_map.vh"
module branch_stack_chk
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`ADDR_BITS-1:0] regAddr,
  input wire logic [63:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [63:0] regRdData_ff,
  input wire logic xferValid
);
  // one clock domain, so one default for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  idle_read_a: assert property (!regRdEn |=> regRdData_ff == 64'h0)
    else $error("read data not idle");
  feature_bit_a: assert property (regRdEn && regAddr == `FEATURE_ID_IDX |=> regRdData_ff[15])
    else $error("feature bit clear");
  cap_width_a: assert property (regRdEn && regAddr == `PERF_CAP_IDX |=> regRdData_ff[63:6] == 58'h0)
    else $error("capability too wide");
  top_range_a: assert property (regRdEn && regAddr == `TOP_REG_IDX |=> regRdData_ff[63:5] == 59'h0)
    else $error("pointer out of range");
  unmapped_a: assert property (regRdEn && regAddr > `FORMAT_SEL_IDX |=> regRdData_ff == 64'h0)
    else $error("unmapped read nonzero");
  cap_mirror_a: assert property (regRdEn && regAddr == `FORMAT_SEL_IDX ##1 regRdEn && regAddr == `PERF_CAP_IDX
    |=> regRdData_ff[5:0] == $past(regRdData_ff[5:0])) else $error("capability differs from format");
  enable_rw_a: assert property (regWrEn && regAddr == `DEBUG_CTRL_IDX ##1 regRdEn && regAddr == `DEBUG_CTRL_IDX
    |=> regRdData_ff[0] == $past(regWrData[0], 2)) else $error("enable not kept");
  top_write_a: assert property (regWrEn && regAddr == `TOP_REG_IDX && !xferValid ##1
    regRdEn && regAddr == `TOP_REG_IDX && !xferValid |=> regRdData_ff[4:0] == $past(regWrData[4:0], 2))
    else $error("pointer write lost");
endmodule
`default_nettype wire

/* File: dv/core_xfer_model.sv */
/* retirement side of the core: presents control transfers to the stack.
   assumes the stack samples one transfer per rising edge. */
`timescale 1ns/1ps
`default_nettype none
module core_xfer_model
(
  input wire logic clk,
  output var logic xferValid,
  output var logic [63:0] xferSrc,
  output var logic [63:0] xferDst,
  output var logic [2:0] xferFlags
);
  // nothing retires until the bench asks
  initial
  begin
    xferValid = 1'b0;
    xferSrc = 64'h0;
    xferDst = 64'h0;
    xferFlags = 3'h0;
  end
  // back-to-back transfers, then stale lines flip so old values never pass
  task automatic burst(input int n, input logic [63:0] s0, input logic [2:0] fl);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      xferValid <= 1'b1;
      xferSrc <= s0 + 64'(k) * 64'h10;
      xferDst <= s0 + 64'(k) * 64'h10 + 64'h800;
      xferFlags <= fl;
    end
    @(posedge clk);
    xferValid <= 1'b0;
    xferSrc <= ~xferSrc;
    xferDst <= ~xferDst;
    xferFlags <= ~fl;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
/* bench for the branch record stack: reset state, formats, wrap, packing.
   assumes the core model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "branch_stack_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] regAddr = 7'h0;
  logic [63:0] regWrData = 64'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic longMode = 1'b1;
  logic [63:0] codeSegBase = 64'h100_0000_0000;
  wire logic [63:0] regRdData_ff, xferSrc, xferDst;
  wire logic [2:0] fl;
  wire logic xferValid;
  logic [63:0] r1, r2, s;
  logic [4:0] expTop = 5'h0;
  int n_fail = 0;
  int compares = 0;
  localparam logic [63:0] S0 = 64'ha0_1234_5670;
  // fmtCase records land twelve edges apart; the count restarts at 0 the cycle after a record
  localparam logic [15:0] CYC_GAP = 16'h000b;
  // 250 MHz core clock
  always #2 clk = ~clk;
  last_branch_record_stack u_dut (.clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_ff,
    .xferValid, .xferSrc, .xferDst, .codeSegBase, .longMode, .xferMispred(fl[2]), .xferInTx(fl[1]),
    .xferTxAbort(fl[0]));
  core_xfer_model u_core (.clk, .xferValid, .xferSrc, .xferDst, .xferFlags(fl));
  // op at a1 (write or read), then a read of a2 in the very next cycle
  task automatic acc(input logic w, input logic [6:0] a1, input logic [63:0] d, input logic [6:0] a2);
    @(posedge clk);
    regWrEn <= w;
    regRdEn <= !w;
    regAddr <= a1;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    regAddr <= a2;
    #1 r1 = regRdData_ff;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 r2 = regRdData_ff;
  endtask
  // stored address: linear formats add the segment base, short modes drop the top half
  function automatic logic [63:0] ea(input logic [63:0] off, input int f);
    logic [63:0] v;
    v = (f == 1 || f >= 6) ? off + codeSegBase : off;
    if (f == 0 || !longMode) v[63:32] = 32'h0;
    return v;
  endfunction
  task automatic resetCase();
    acc(1'b0, `TOP_REG_IDX, 64'h0, `DEBUG_CTRL_IDX);
    `CHK(r1, 64'h0)
    `CHK(r2, 64'h0)
    acc(1'b0, `FEATURE_ID_IDX, 64'h0, 7'h70);
    `CHK(r1[15], 1'b1)
    `CHK(r2, 64'h0)
    acc(1'b1, `PERF_CAP_IDX, 64'h3f, `PERF_CAP_IDX);
    `CHK(r2[5:0], `FORMAT_RESET)
    acc(1'b0, `FORMAT_SEL_IDX, 64'h0, `PERF_CAP_IDX);
    `CHK(r1[5:0], `FORMAT_RESET)
    `CHK(r1[8], `LEGACY_RESET)
    u_core.burst(2, S0, 3'h0);
    acc(1'b0, `TOP_REG_IDX, 64'h0, `TOP_REG_IDX);
    `CHK(r1, 64'h0)
    acc(1'b1, `DEBUG_CTRL_IDX, 64'h1, `DEBUG_CTRL_IDX);
    `CHK(r2[0], 1'b1)
  endtask
  task automatic fmtCase(input int f, input logic lm);
    @(posedge clk);
    longMode <= lm;
    acc(1'b1, `FORMAT_SEL_IDX, 64'(f), `PERF_CAP_IDX);
    `CHK(r2[5:0], 6'(f))
    u_core.burst(1, S0, 3'h7);
    expTop = expTop + 5'h1;
    acc(1'b0, `TOP_REG_IDX, 64'h0, `SRC_ARRAY_BASE + expTop);
    `CHK(r1, {59'h0, expTop})
    s = ea(S0, f);
    if (f == 3 || f == 6) s[63] = 1'b1;
    if (f == 4) s[63:61] = 3'h7;
    `CHK(r2, s)
    acc(1'b0, `DST_ARRAY_BASE + expTop, 64'h0, `INFO_ARRAY_BASE + expTop);
    s = ea(S0 + 64'h800, f);
    `CHK(r1[47:0], s[47:0])
    if (f != 6) `CHK(r1[63:48], s[63:48])
    if (f == 6) `CHK(r1[63:48], CYC_GAP)
    // info word: flags on top, elapsed cycles in the low half-word
    s = 64'h0;
    if (f == 5) s[63:61] = 3'h7;
    if (f == 7) s[63] = 1'b1;
    if (f == 5 || f == 7) s[15:0] = CYC_GAP;
    `CHK(r2, s)
  endtask
  task automatic wrapCase();
    acc(1'b1, `TOP_REG_IDX, 64'h1e, `TOP_REG_IDX);
    `CHK(r2[4:0], 5'h1e)
    expTop = 5'h1e;
    u_core.burst(32, S0, 3'h0);
    acc(1'b0, `TOP_REG_IDX, 64'h0, `SRC_ARRAY_BASE);
    `CHK(r1[4:0], expTop)
    `CHK(r2, ea(S0 + 64'h10, 2))
  endtask
  // packed variant: target in the high half, source in the low half
  task automatic legacyCase();
    acc(1'b1, `FORMAT_SEL_IDX, 64'h102, `FORMAT_SEL_IDX);
    u_core.burst(1, S0, 3'h0);
    expTop = expTop + 5'h1;
    acc(1'b0, `SRC_ARRAY_BASE + expTop, 64'h0, `TOP_REG_IDX);
    `CHK(r1, {S0[31:0] + 32'h800, S0[31:0]})
    // packed record leaves the destination slot as the wrap left it
    acc(1'b1, `DST_ARRAY_BASE + 7'h03, 64'h5a5a_0123_4567_89ab, `DST_ARRAY_BASE + expTop);
    `CHK(r2, ea(S0 + 64'h800, 2))
    acc(1'b0, `DST_ARRAY_BASE + 7'h03, 64'h0, `TOP_REG_IDX);
    `CHK(r1, 64'h5a5a_0123_4567_89ab)
    `CHK(r2[4:0], expTop)
  endtask
  // second reset in mid-run: control state back to reset values, recording off
  task automatic rerunReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    acc(1'b0, `TOP_REG_IDX, 64'h0, `FORMAT_SEL_IDX);
    `CHK(r1, 64'h0)
    `CHK(r2, {55'h0, `LEGACY_RESET, 2'h0, `FORMAT_RESET})
    acc(1'b0, `DEBUG_CTRL_IDX, 64'h0, `PERF_CAP_IDX);
    `CHK(r1, 64'h0)
    `CHK(r2[5:0], `FORMAT_RESET)
    u_core.burst(1, S0, 3'h0);
    acc(1'b0, `TOP_REG_IDX, 64'h0, `TOP_REG_IDX);
    `CHK(r1, 64'h0)
  endtask
  task automatic summarize();
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    resetCase();
    for (int f = 0; f < 8; f++) fmtCase(f, 1'b1);
    fmtCase(2, 1'b0);
    wrapCase();
    legacyCase();
    rerunReset();
    summarize();
  end
  // a hang counts as a failure
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
bind last_branch_record_stack branch_stack_chk u_chk (.clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
  .regRdData_ff, .xferValid);
`default_nettype wire
